// [tmw_pkg.sv]
/*
 * constants shared by the 8-bit timer waveform block: register indices,
 * field positions, reset values, mode codes and prescaler width.
 * assumes a 32-bit APB master; register byte address is four times its index.
 */
package tmw_pkg;

    // register indices; byte address = index * 4
    localparam logic [9:0] IDX_CONTROL_A = 10'h0B0;
    localparam logic [9:0] IDX_CONTROL_B = 10'h0B1;
    localparam logic [9:0] IDX_COUNT = 10'h0B2;
    localparam logic [9:0] IDX_COMPARE_A = 10'h0B3;
    localparam logic [9:0] IDX_COMPARE_B = 10'h0B4;
    localparam logic [9:0] IDX_CLOCK_SRC = 10'h0B6;
    localparam logic [9:0] IDX_STATUS = 10'h0B7;
    localparam int ADDR_W = 12;

    // control A fields
    localparam int CA_COM_A_HI = 7;
    localparam int CA_COM_A_LO = 6;
    localparam int CA_COM_B_HI = 5;
    localparam int CA_COM_B_LO = 4;
    localparam int CA_WGM_HI = 1;
    localparam int CA_WGM_LO = 0;
    localparam logic [7:0] CA_WMASK = 8'hF3;
    // control B fields
    localparam int CB_FOC_A = 7;
    localparam int CB_FOC_B = 6;
    localparam int CB_WGM2 = 3;
    localparam int CB_CS_HI = 2;
    localparam int CB_CS_LO = 0;
    localparam logic [7:0] CB_RMASK = 8'h0F;
    // clock source register
    localparam int CK_ASYNC = 0;
    // status register fields
    localparam int ST_DIR_UP = 0;
    localparam int ST_WAVE_A = 1;
    localparam int ST_WAVE_B = 2;
    localparam int ST_RUNNING = 3;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam int PRESC_W = 10;

    // waveform generation modes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_FF = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_PC_OCA = 3'h5;
    localparam logic [2:0] WM_FAST_OCA = 3'h7;

    typedef enum logic [1:0] {
        KIND_PLAIN = 2'h0,
        KIND_FAST = 2'h1,
        KIND_PHASE = 2'h2
    } tmw_kind_type;

endpackage : tmw_pkg

// [tmw_timer.sv]
/*
 * 8-bit timer/counter with two compare channels, waveform modes, forced
 * compares, prescaled clock selection and an APB register slave.
 * assumes: APB master on CLK; the oscillator pin is asynchronous to CLK and
 * much slower; port direction logic outside honours the output enables.
 */
// Behaviour
// - nonzero channel-B output mode hands the pin to the waveform output.
// - non-PWM channel-B modes: disconnect, toggle, clear, set on match.
// - fast PWM channel B: 01 reserved, 10 clear/set-bottom, 11 inverse.
// - fast PWM, compare equals TOP: ignore match, act at bottom.
// - phase correct: 10 clears up-match, sets down-match; 11 inverse.
// - phase correct, compare equals TOP: ignore match, act at TOP.
// - control A bits 3:2 and control B bits 5:4 read zero.
// - mode decode: 0 normal, 1/5 phase, 2 clear-on-match, 3/7 fast.
// - TOP is 0xFF in modes 0,1,3 and compare A in 2,5,7.
// - compare update and overflow timing follow the mode.
// - force bits act only in non-PWM modes.
// - force bit is a one-shot strobe acting through the output mode.
// - forced compare raises no event and never clears the counter.
// - force bits read as zero.
// - clock select: stop, undivided, /8 /32 /64 /128 /256 /1024.
// - counter register is directly readable and writable.
// - counter write blocks compare match on the next timer tick.
// - source clock is CLK unless async select picks oscillator pin.
// - both compare values are compared with the counter continuously.
module tmw_timer
    import tmw_pkg::*;
(
    input wire logic CLK, // system clock, 200 MHz
    input wire logic RSTN, // synchronous reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high writes
    input wire logic [tmw_pkg::ADDR_W-1:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped address
    input wire logic OSC_PIN, // asynchronous oscillator pin clock
    output logic CHAN_A_WAVE_PIN, // channel A waveform level
    output logic CHAN_A_WAVE_EN, // channel A owns the pin
    output logic CHAN_B_WAVE_PIN, // channel B waveform level
    output logic CHAN_B_WAVE_EN, // channel B owns the pin
    output logic COMPARE_A_EVT, // channel A match pulse
    output logic COMPARE_B_EVT, // channel B match pulse
    output logic OVERFLOW_EVT // overflow flag set pulse
);
    import tmw_pkg::*;

    function automatic logic presc_hit(input logic [2:0] cs, input logic [PRESC_W-1:0] p);
        logic hit;
        hit = 1'b0;
        case (cs)
            3'h2: hit = &p[2:0];
            3'h3: hit = &p[4:0];
            3'h4: hit = &p[5:0];
            3'h5: hit = &p[6:0];
            3'h6: hit = &p[7:0];
            3'h7: hit = &p[9:0];
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // next waveform level for one channel
    // tog_ok: only channel A may toggle in PWM, and only with the high mode bit set
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] com,
        input tmw_kind_type kind,
        input logic tog_ok,
        input logic up,
        input logic match,
        input logic at_bottom,
        input logic at_top,
        input logic eq_top
    );
        logic nx;
        nx = cur;
        case (kind)
            KIND_PLAIN: begin
                if (match) begin
                    case (com)
                        2'b01: nx = ~cur;
                        2'b10: nx = 1'b0;
                        2'b11: nx = 1'b1;
                        default: nx = cur;
                    endcase
                end
            end
            KIND_FAST: begin
                if (com == 2'b01) begin
                    if (tog_ok && match) nx = ~cur;
                end else if (com[1]) begin
                    if (match && !eq_top) nx = com[0];
                    if (at_bottom) nx = ~com[0];
                end
            end
            KIND_PHASE: begin
                if (com == 2'b01) begin
                    if (tog_ok && match) nx = ~cur;
                end else if (com[1]) begin
                    if (eq_top) begin
                        if (at_top) nx = com[0];
                    end else if (match) begin
                        nx = up ? com[0] : ~com[0];
                    end
                end
            end
            default: nx = cur;
        endcase
        return nx;
    endfunction

    logic [7:0] ctrl_a_q, ctrl_a_d;
    logic [7:0] ctrl_b_q, ctrl_b_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] chan_a_top_source_buf_q, chan_a_top_source_buf_d, ocrb_buf_q, ocrb_buf_d;
    logic [7:0] chan_a_top_source_q, chan_a_top_source_d, ocrb_q, ocrb_d;
    logic async_sel_q, async_sel_d;
    logic up_q, up_d;
    logic block_q, block_d;
    logic [PRESC_W-1:0] presc_q, presc_d;
    logic osc_m_q, osc_s_q, osc_p_q;
    logic wave_a_q, wave_a_d, wave_b_q, wave_b_d;
    logic en_a_q, en_b_q, evt_a_q, evt_b_q, ovf_q;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pslverr_q, pslverr_d;

    // register access decode
    wire [9:0] idx = PADDR[ADDR_W-1:2];
    wire setup = PSEL && !PENABLE;
    wire commit = PSEL && PENABLE && pready_q;
    wire wr = commit && PWRITE && PSTRB[0];
    wire hit_ca = (idx == IDX_CONTROL_A);
    wire hit_cb = (idx == IDX_CONTROL_B);
    wire hit_cnt = (idx == IDX_COUNT);
    wire hit_oa = (idx == IDX_COMPARE_A);
    wire hit_ob = (idx == IDX_COMPARE_B);
    wire hit_ck = (idx == IDX_CLOCK_SRC);
    wire hit_st = (idx == IDX_STATUS);
    // unmapped offsets answer with an error and change nothing
    wire mapped = hit_ca | hit_cb | hit_cnt | hit_oa | hit_ob | hit_ck | hit_st;
    wire [7:0] wbyte = PWDATA[7:0];

    // mode decode
    // reserved modes 4 and 6 count as normal mode, TOP at MAX, no PWM
    wire [2:0] wmode = {ctrl_b_q[CB_WGM2], ctrl_a_q[CA_WGM_HI:CA_WGM_LO]};
    wire is_fast = (wmode == WM_FAST_FF) || (wmode == WM_FAST_OCA);
    wire is_phase = (wmode == WM_PC_FF) || (wmode == WM_PC_OCA);
    wire is_ctc = (wmode == WM_CTC);
    wire is_pwm = is_fast || is_phase;
    wire tmw_kind_type kind = is_fast ? KIND_FAST : (is_phase ? KIND_PHASE : KIND_PLAIN);
    wire top_var = (wmode == WM_CTC) || (wmode == WM_PC_OCA) || (wmode == WM_FAST_OCA);
    wire [7:0] top = top_var ? chan_a_top_source_q : CNT_MAX;
    wire at_top_cnt = (cnt_q == top);

    // source clock: CLK, or synchronised oscillator rising edge
    wire osc_rise = osc_s_q && !osc_p_q;
    wire src_tick = async_sel_q ? osc_rise : 1'b1;
    wire [2:0] cs = ctrl_b_q[CB_CS_HI:CB_CS_LO];
    wire presc_tap = (cs == 3'h1) || presc_hit(cs, presc_q);
    wire tick = src_tick && presc_tap;

    // continuous compare; qualified by tick; blocked after write
    wire match_a = tick && !block_q && (cnt_q == chan_a_top_source_q);
    wire match_b = tick && !block_q && (cnt_q == ocrb_q);

    // force only outside PWM; strobe from the control B write
    wire force_a = wr && hit_cb && wbyte[CB_FOC_A] && !is_pwm;
    wire force_b = wr && hit_cb && wbyte[CB_FOC_B] && !is_pwm;

    logic wrap_ev, top_ev, upd_ev, ovf_ev;

    // counter sequencing per mode
    always_comb begin
        cnt_d = cnt_q;
        up_d = up_q;
        wrap_ev = 1'b0;
        top_ev = 1'b0;
        upd_ev = 1'b0;
        ovf_ev = 1'b0;
        if (tick) begin
            if (is_phase) begin
                // up to top, then down to bottom
                if (up_q) begin
                    if (at_top_cnt) begin
                        up_d = 1'b0;
                        top_ev = 1'b1;
                        upd_ev = 1'b1;
                        cnt_d = (cnt_q == CNT_BOTTOM) ? cnt_q : cnt_q - 8'h01;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end else if (cnt_q == CNT_BOTTOM) begin
                    up_d = 1'b1;
                    ovf_ev = 1'b1;
                    cnt_d = cnt_q + 8'h01;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end else if (is_fast || is_ctc) begin
                // only the counter reaching TOP clears; the force path never reaches here
                if (at_top_cnt) begin
                    cnt_d = CNT_BOTTOM;
                    wrap_ev = is_fast;
                    upd_ev = is_fast;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
                // overflow at TOP in mode 7, otherwise at MAX
                ovf_ev = (wmode == WM_FAST_OCA) ? at_top_cnt : (cnt_q == CNT_MAX);
            end else begin
                cnt_d = cnt_q + 8'h01;
                ovf_ev = (cnt_q == CNT_MAX);
            end
        end
        if (wr && hit_cnt) begin
            cnt_d = wbyte;
        end
    end

    // block set by a counter write, cleared by the next tick
    // without it a written value equal to a compare value would match at once
    assign block_d = (wr && hit_cnt) ? 1'b1 : (tick ? 1'b0 : block_q);
    // free running: a new clock select starts partway into a prescaler period
    assign presc_d = src_tick ? presc_q + {{(PRESC_W-1){1'b0}}, 1'b1} : presc_q;

    // compare buffers: immediate outside PWM, at TOP or bottom in PWM
    assign chan_a_top_source_buf_d = (wr && hit_oa) ? wbyte : chan_a_top_source_buf_q;
    assign ocrb_buf_d = (wr && hit_ob) ? wbyte : ocrb_buf_q;
    assign chan_a_top_source_d = (!is_pwm || upd_ev) ? chan_a_top_source_buf_d : chan_a_top_source_q;
    assign ocrb_d = (!is_pwm || upd_ev) ? ocrb_buf_d : ocrb_q;

    assign ctrl_a_d = (wr && hit_ca) ? (wbyte & CA_WMASK) : ctrl_a_q;
    assign ctrl_b_d = (wr && hit_cb) ? (wbyte & CB_RMASK) : ctrl_b_q;
    assign async_sel_d = (wr && hit_ck) ? wbyte[CK_ASYNC] : async_sel_q;

    wire [1:0] com_a = ctrl_a_q[CA_COM_A_HI:CA_COM_A_LO];
    wire [1:0] com_b = ctrl_a_q[CA_COM_B_HI:CA_COM_B_LO];
    wire eq_top_a = (chan_a_top_source_q == top);
    wire eq_top_b = (ocrb_q == top);
    // a forced compare reaches the waveform only, never the events or the counter
    wire wave_hit_a = match_a | force_a;
    wire wave_hit_b = match_b | force_b;
    assign wave_b_d = wave_next(wave_b_q, com_b, kind, 1'b0, up_q, wave_hit_b,
        wrap_ev, top_ev, eq_top_b);
    // channel A toggles in PWM when the high mode bit is set
    assign wave_a_d = wave_next(wave_a_q, com_a, kind, ctrl_b_q[CB_WGM2], up_q,
        wave_hit_a, wrap_ev, top_ev, eq_top_a);

    // read mux; reserved and force bits read zero
    // status is a read-only view of the running state
    wire [7:0] status = {4'h0, (cs != 3'h0), wave_b_q, wave_a_q, up_q};
    always_comb begin
        prdata_d = 32'h0000_0000;
        case (1'b1)
            hit_ca: prdata_d[7:0] = ctrl_a_q;
            hit_cb: prdata_d[7:0] = ctrl_b_q & CB_RMASK;
            hit_cnt: prdata_d[7:0] = cnt_q;
            hit_oa: prdata_d[7:0] = chan_a_top_source_buf_q;
            hit_ob: prdata_d[7:0] = ocrb_buf_q;
            hit_ck: prdata_d[CK_ASYNC] = async_sel_q;
            hit_st: prdata_d[7:0] = status;
            default: prdata_d = 32'h0000_0000;
        endcase
    end
    assign pslverr_d = !mapped;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctrl_a_q <= RST_BYTE;
            ctrl_b_q <= RST_BYTE;
            cnt_q <= RST_BYTE;
            chan_a_top_source_buf_q <= RST_BYTE;
            ocrb_buf_q <= RST_BYTE;
            chan_a_top_source_q <= RST_BYTE;
            ocrb_q <= RST_BYTE;
            async_sel_q <= 1'b0;
            up_q <= 1'b1;
            block_q <= 1'b0;
            presc_q <= '0;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            cnt_q <= cnt_d;
            chan_a_top_source_buf_q <= chan_a_top_source_buf_d;
            ocrb_buf_q <= ocrb_buf_d;
            chan_a_top_source_q <= chan_a_top_source_d;
            ocrb_q <= ocrb_d;
            async_sel_q <= async_sel_d;
            up_q <= up_d;
            block_q <= block_d;
            presc_q <= presc_d;
        end
    end

    // oscillator pin: two stages, then a third for edge detection
    // the pin must stay well below half of CLK or edges are lost
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            osc_m_q <= 1'b0;
            osc_s_q <= 1'b0;
            osc_p_q <= 1'b0;
        end else begin
            osc_m_q <= OSC_PIN;
            osc_s_q <= osc_m_q;
            osc_p_q <= osc_s_q;
        end
    end

    // waveform, enables and event pulses
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
            evt_a_q <= 1'b0;
            evt_b_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            wave_a_q <= wave_a_d;
            wave_b_q <= wave_b_d;
            en_a_q <= |ctrl_a_d[CA_COM_A_HI:CA_COM_A_LO];
            // any nonzero mode bit takes the pin
            en_b_q <= |ctrl_a_d[CA_COM_B_HI:CA_COM_B_LO];
            // events come from real matches only
            evt_a_q <= match_a;
            evt_b_q <= match_b;
            ovf_q <= ovf_ev;
        end
    end

    // apb: ready answers in the access cycle right after setup
    // read data is latched in setup, so a running count reads as it stood then
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && pslverr_d;
            prdata_q <= (setup && !PWRITE) ? prdata_d : 32'h0000_0000;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign CHAN_A_WAVE_PIN = wave_a_q;
    assign CHAN_A_WAVE_EN = en_a_q;
    assign CHAN_B_WAVE_PIN = wave_b_q;
    assign CHAN_B_WAVE_EN = en_b_q;
    assign COMPARE_A_EVT = evt_a_q;
    assign COMPARE_B_EVT = evt_b_q;
    assign OVERFLOW_EVT = ovf_q;

endmodule // tmw_timer

// [tmw_timer_props.sv]
/* port checker for the timer block.
   bound to tmw_timer from the testbench top file. */
module tmw_props
    import tmw_pkg::*;
(
    input wire logic CLK, // clock
    input wire logic RSTN, // reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access
    input wire logic PWRITE, // apb write
    input wire logic [tmw_pkg::ADDR_W-1:0] PADDR, // apb address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb strobes
    input wire logic [31:0] PRDATA, // apb read data
    input wire logic PREADY, // apb ready
    input wire logic PSLVERR, // apb error
    input wire logic CHAN_A_WAVE_EN, // chan a owns pin
    input wire logic CHAN_B_WAVE_EN, // chan b owns pin
    input wire logic CHAN_B_WAVE_PIN, // chan b level
    input wire logic COMPARE_B_EVT, // chan b match
    input wire logic OVERFLOW_EVT // overflow
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    wire [9:0] idx = PADDR[11:2];
    wire setup = PSEL && !PENABLE;
    wire commit = PSEL && PENABLE && PREADY;
    wire mapped = idx inside {IDX_CONTROL_A, IDX_CONTROL_B, IDX_COUNT, IDX_COMPARE_A,
        IDX_COMPARE_B, IDX_CLOCK_SRC, IDX_STATUS};
    sequence ctrl_a_write;
        commit && PWRITE && PSTRB[0] && idx == IDX_CONTROL_A;
    endsequence
    sequence read_of(logic [9:0] i);
        commit && !PWRITE && idx == i;
    endsequence
    ready_next_a: assert property (setup |=> PREADY)
        else $error("ready missing after setup");
    ready_cause_a: assert property (PREADY |-> $past(setup))
        else $error("ready without setup");
    unmapped_err_a: assert property (setup && !mapped |=> PSLVERR)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (setup && mapped |=> !PSLVERR)
        else $error("error on mapped access");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside access");
    ctrl_a_res_a: assert property (read_of(IDX_CONTROL_A) |-> PRDATA[3:2] == 2'h0)
        else $error("control a reserved bits set");
    ctrl_b_res_a: assert property (read_of(IDX_CONTROL_B) |-> PRDATA[7:4] == 4'h0)
        else $error("control b force or reserved bits set");
    pin_owner_a: assert property (ctrl_a_write |-> ##2
        CHAN_B_WAVE_EN == $past(|PWDATA[5:4], 2) && CHAN_A_WAVE_EN == $past(|PWDATA[7:6], 2))
        else $error("pin enable does not follow output mode");
    reset_quiet_a: assert property (disable iff (1'b0) !RSTN |=> !(PREADY || PSLVERR
        || CHAN_B_WAVE_EN || CHAN_B_WAVE_PIN || COMPARE_B_EVT || OVERFLOW_EVT))
        else $error("output active after reset");
endmodule // tmw_props

// [tmw_timer_tb.sv]
/* directed testbench for tmw_timer over apb.
   assumes the package, design and checker are compiled first. */
module tmw_timer_tb
    import tmw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, OSC_PIN = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
    logic [3:0] PSTRB = 4'h0;
    logic PREADY, PSLVERR, CHAN_A_WAVE_PIN, CHAN_A_WAVE_EN, CHAN_B_WAVE_PIN, CHAN_B_WAVE_EN;
    logic COMPARE_A_EVT, COMPARE_B_EVT, OVERFLOW_EVT;
    int fails = 0, cmp_count = 0, cyc = 0, evb = 0, eva = 0;
    logic [9:0] rst_regs [3] = '{IDX_CONTROL_A, IDX_CONTROL_B, IDX_COUNT};
    logic [7:0] frc_mode [3] = '{8'h30, 8'h20, 8'h10};
    logic [7:0] frc_exp [3] = '{8'h01, 8'h00, 8'h01};
    logic [7:0] pwm_mode [4] = '{8'h23, 8'h33, 8'h21, 8'h31};
    int span [9] = '{64, 100, 1024, 1024, 1024, 1024, 1024, 1024, 320};
    logic [7:0] rate [9] = '{8'h00, 8'h64, 8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h14};

    tmw_timer uut (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
        .PREADY, .PSLVERR, .OSC_PIN, .CHAN_A_WAVE_PIN, .CHAN_A_WAVE_EN, .CHAN_B_WAVE_PIN,
        .CHAN_B_WAVE_EN, .COMPARE_A_EVT, .COMPARE_B_EVT, .OVERFLOW_EVT);

    initial forever #2.5 CLK = ~CLK;

    // slow oscillator, one rising edge every 16 cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        OSC_PIN <= cyc[3];
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end

    // counted mid-cycle so a read at a clock edge never races it
    always @(negedge CLK) if (COMPARE_B_EVT === 1'b1) evb++;
    always @(negedge CLK) if (COMPARE_A_EVT === 1'b1) eva++;

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(string s, logic [7:0] x, logic [7:0] g);
        cmp_count++;
        if (g !== x) begin
            $display("[ERR] %s expected %h seen %h", s, x, g);
            fails++;
        end
    endtask

    task automatic xfer(input logic [9:0] i, input logic w, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {i, 2'b00};
        PWDATA <= {24'h00_0000, d};
        PSTRB <= 4'hF;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic wr(logic [9:0] i, logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(i, 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [9:0] i, output logic [7:0] v);
        logic [31:0] r;
        logic e;
        xfer(i, 1'b0, 8'h00, r, e);
        v = r[7:0];
    endtask

    // k 0 waits for a chan b match pulse, 1 for an overflow pulse
    task automatic wait_evt(int k);
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (((k == 0) ? COMPARE_B_EVT : OVERFLOW_EVT) !== 1'b1 && n < 2000);
        chk("event_seen", 8'h01, 8'(n < 2000));
    endtask

    initial begin
        logic [7:0] v, a, b;
        logic [31:0] r;
        logic e;
        int e0, dd;
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        for (int k = 0; k < 3; k++) begin
            rd(rst_regs[k], v);
            chk("reset_value", 8'h00, v);
        end
        wr(IDX_CONTROL_A, 8'hFF);
        rd(IDX_CONTROL_A, v);
        chk("ctrl_a_mask", 8'hF3, v);
        wr(IDX_CONTROL_A, 8'h00);
        wr(IDX_CONTROL_B, 8'hF0);
        rd(IDX_CONTROL_B, v);
        chk("ctrl_b_mask", 8'h00, v);
        xfer(10'h0B5, 1'b0, 8'h00, r, e);
        chk("unmapped_err", 8'h01, {7'h00, e});
        wr(IDX_CONTROL_A, 8'h02);
        wr(IDX_COUNT, 8'hA5);
        wr(IDX_CONTROL_B, 8'h80);
        rd(IDX_COUNT, v);
        chk("count_rw", 8'hA5, v);
        e0 = evb;
        for (int k = 0; k < 3; k++) begin
            wr(IDX_CONTROL_A, frc_mode[k]);
            wr(IDX_CONTROL_B, 8'h40);
            chk("forced_wave", frc_exp[k], {7'h00, CHAN_B_WAVE_PIN});
        end
        chk("force_no_event", 8'(e0), 8'(evb));
        chk("wave_b_en", 8'h01, {7'h00, CHAN_B_WAVE_EN});
        wr(IDX_CONTROL_A, 8'h23);
        wr(IDX_CONTROL_B, 8'h40);
        chk("pwm_force_off", 8'h01, {7'h00, CHAN_B_WAVE_PIN});
        wr(IDX_CONTROL_A, 8'h02);
        wr(IDX_COMPARE_A, 8'h10);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CONTROL_B, 8'h01);
        e0 = eva;
        repeat (100) @(posedge CLK);
        dd = eva - e0;
        rd(IDX_COUNT, v);
        chk("ctc_top", 8'h01, 8'(v <= 8'h10));
        chk("ctc_a_events", 8'h01, 8'(dd >= 5 && dd <= 6));
        rd(IDX_COMPARE_A, v);
        chk("compare_a_rd", 8'h10, v);
        rd(IDX_STATUS, v);
        chk("status_run", 8'h0D, v);
        wr(IDX_CONTROL_B, 8'h00);
        wr(IDX_CONTROL_A, 8'h10);
        wr(IDX_COMPARE_B, 8'h40);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CONTROL_B, 8'h01);
        wait_evt(0);
        chk("toggle_match", 8'h00, {7'h00, CHAN_B_WAVE_PIN});
        e0 = evb;
        wr(IDX_COUNT, 8'h40);
        repeat (20) @(posedge CLK);
        chk("match_blocked", 8'(e0), 8'(evb));
        for (int k = 0; k < 4; k++) begin
            wr(IDX_CONTROL_B, 8'h00);
            wr(IDX_CONTROL_A, pwm_mode[k]);
            wr(IDX_COUNT, 8'h10);
            wr(IDX_CONTROL_B, 8'h01);
            wait_evt(0);
            chk("pwm_match", {7'h00, pwm_mode[k][4]}, {7'h00, CHAN_B_WAVE_PIN});
            wait_evt(int'(pwm_mode[k][1]));
            chk("pwm_second", {7'h00, ~pwm_mode[k][4]}, {7'h00, CHAN_B_WAVE_PIN});
        end
        wr(IDX_CONTROL_B, 8'h00);
        wr(IDX_CONTROL_A, 8'h20);
        wr(IDX_COMPARE_B, 8'h10);
        wr(IDX_COUNT, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CONTROL_A, k ? 8'h21 : 8'h23);
            wr(IDX_CONTROL_B, 8'h09);
            wait_evt(1);
            e0 = cyc;
            wait_evt(1);
            chk("chan_a_top_source_top_period", k ? 8'h20 : 8'h11, 8'(cyc - e0));
            chk("eq_top_wave", k ? 8'h00 : 8'h01, {7'h00, CHAN_B_WAVE_PIN});
            wr(IDX_CONTROL_B, 8'h00);
        end
        wr(IDX_CONTROL_A, 8'h00);
        for (int k = 0; k < 9; k++) begin
            wr(IDX_CLOCK_SRC, {7'h00, k == 8});
            wr(IDX_CONTROL_B, (k == 8) ? 8'h01 : 8'(k));
            rd(IDX_COUNT, a);
            repeat (span[k] - 3) @(posedge CLK);
            rd(IDX_COUNT, b);
            dd = (b - a) & 8'hFF;
            chk("tick_rate", rate[k], (dd + 1 >= rate[k] && dd <= rate[k] + 1) ? rate[k] : 8'(dd));
        end
        end_sim();
    end
endmodule // tmw_timer_tb

bind tmw_timer tmw_props chk_i (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .CHAN_A_WAVE_EN, .CHAN_B_WAVE_EN, .CHAN_B_WAVE_PIN,
    .COMPARE_B_EVT, .OVERFLOW_EVT);
